// *** hw/frx_defs.svh ***
// Constants for the file register execution datapath
`ifndef FRX_DEFS_SVH
`define FRX_DEFS_SVH
`define FRX_DATA_W 8
`define FRX_ADDR_W 7
`define FRX_FILE_DEPTH 128
`define FRX_W_RESET 8'h00
`define FRX_FILE_RESET 8'h00
`define FRX_DEST_WORK 1'b0
`define FRX_DEST_FILE 1'b1
`define FRX_INC_STEP 8'h01
`endif

// *** hw/frx_pkg.sv ***
// Types for the file register execution datapath
package frx_pkg;
  typedef enum logic [2:0] {
    op_none,
    increment_file_op,
    or_work_with_file_op,
    move_file_op,
    move_work_to_file_op
  } frx_op_type;
endpackage : frx_pkg

// *** hw/frx_file_mem.sv ***
// File register memory with registered read data
`timescale 1ns/1ns
`include "frx_defs.svh"
module frx_file_mem #(
  parameter int ADDR_W = `FRX_ADDR_W,
  parameter int DATA_W = `FRX_DATA_W,
  parameter int DEPTH = `FRX_FILE_DEPTH
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] read_addr_i,
  output logic [DATA_W-1:0] read_data_o,
  input wire logic write_en_i,
  input wire logic [ADDR_W-1:0] write_addr_i,
  input wire logic [DATA_W-1:0] write_data_i
);
  logic [DATA_W-1:0] mem [DEPTH];

  // Storage write, cleared at reset
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= DATA_W'(`FRX_FILE_RESET);
      end
    end else if (write_en_i) begin
      mem[write_addr_i] <= write_data_i;
    end
  end

  // Registered read port
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      read_data_o <= DATA_W'(`FRX_FILE_RESET);
    end else begin
      read_data_o <= mem[read_addr_i];
    end
  end
endmodule : frx_file_mem

// *** hw/frx_exec.sv ***
// Execution datapath for increment, OR, move file and move work operations
`timescale 1ns/1ns
`include "frx_defs.svh"
module frx_exec #(
  parameter int ADDR_W = `FRX_ADDR_W,
  parameter int DATA_W = `FRX_DATA_W,
  parameter int DEPTH = `FRX_FILE_DEPTH
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire frx_pkg::frx_op_type op_i,
  input wire logic [ADDR_W-1:0] file_addr_i,
  input wire logic dest_i,
  output logic busy_o,
  output logic done_o,
  output logic [DATA_W-1:0] work_o,
  output logic zero_o,
  output logic [DATA_W-1:0] result_o
);
  // ****************************************
  // State and captured instruction
  // ****************************************
  typedef enum logic [1:0] {
    st_idle,
    st_read,
    st_exec
  } frx_state_type;

  frx_state_type state;
  frx_pkg::frx_op_type op;
  logic [ADDR_W-1:0] addr;
  logic dest;
  logic [DATA_W-1:0] file_data;
  logic [DATA_W-1:0] next_result;
  logic file_we;
  logic work_we;
  logic zero_we;

  // Zero detection shared by every flag update
  function automatic logic frx_is_zero(input logic [DATA_W-1:0] value);
    return value == '0;
  endfunction : frx_is_zero

  // ****************************************
  // File register storage
  // ****************************************
  frx_file_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .DEPTH(DEPTH)
  ) u_mem (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .read_addr_i(addr),
    .read_data_o(file_data),
    .write_en_i(file_we),
    .write_addr_i(addr),
    .write_data_i(next_result)
  );

  // Sequencer: capture, read file, execute
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state <= st_idle;
      op <= frx_pkg::op_none;
      addr <= '0;
      dest <= `FRX_DEST_WORK;
    end else begin
      case (state)
        st_idle: begin
          if (start_i) begin
            op <= op_i;
            addr <= file_addr_i;
            dest <= dest_i;
            state <= st_read;
          end
        end
        st_read: state <= st_exec;
        st_exec: state <= st_idle;
        default: state <= st_idle;
      endcase
    end
  end

  // ****************************************
  // Result and write enables
  // ****************************************
  always_comb begin
    next_result = file_data;
    file_we = 1'b0;
    work_we = 1'b0;
    zero_we = 1'b0;
    if (state == st_exec) begin
      case (op)
        frx_pkg::increment_file_op: begin
          next_result = DATA_W'(file_data + DATA_W'(`FRX_INC_STEP));
          zero_we = 1'b1;
        end
        frx_pkg::or_work_with_file_op: begin
          next_result = work_o | file_data;
          zero_we = 1'b1;
        end
        frx_pkg::move_file_op: begin
          next_result = file_data;
          zero_we = 1'b1;
        end
        frx_pkg::move_work_to_file_op: begin
          next_result = work_o;
        end
        default: next_result = file_data;
      endcase
      if (op == frx_pkg::move_work_to_file_op) begin
        file_we = 1'b1;
      end else if (op != frx_pkg::op_none) begin
        file_we = (dest == `FRX_DEST_FILE);
        work_we = (dest == `FRX_DEST_WORK);
      end
    end
  end

  // Working register update
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      work_o <= DATA_W'(`FRX_W_RESET);
    end else if (work_we) begin
      work_o <= next_result;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      zero_o <= 1'b0;
    end else if (zero_we) begin
      zero_o <= frx_is_zero(next_result);
    end
  end

  // Result and completion outputs
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      result_o <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= (state == st_exec);
      if (state == st_exec) begin
        result_o <= next_result;
      end
    end
  end

  assign busy_o = (state != st_idle);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  a_inc_result: assert property (state == st_exec && op == frx_pkg::increment_file_op |=>
    result_o == DATA_W'($past(file_data) + 1)) else $error("increment result wrong");
  a_dest_work: assert property (state == st_exec && op != frx_pkg::op_none &&
    op != frx_pkg::move_work_to_file_op && dest == 1'b0 |=> work_o == result_o)
    else $error("work destination not written");
  a_dest_file: assert property (state == st_exec && dest == 1'b1 |=> $stable(work_o))
    else $error("work changed for file destination");
  a_zero_update: assert property (zero_we |=> zero_o == (result_o == '0))
    else $error("zero flag not updated");
  a_or_result: assert property (state == st_exec && op == frx_pkg::or_work_with_file_op |=>
    result_o == ($past(work_o) | $past(file_data))) else $error("OR result wrong");
  a_move_result: assert property (state == st_exec && op == frx_pkg::move_file_op |=>
    result_o == $past(file_data)) else $error("move result wrong");
  a_move_work_to_file_op_flags: assert property (state == st_exec && op == frx_pkg::move_work_to_file_op |=>
    $stable(zero_o) && $stable(work_o)) else $error("move to file touched flags");
  a_move_work_to_file_op_store: assert property (state == st_exec && op == frx_pkg::move_work_to_file_op |->
    file_we && next_result == work_o) else $error("move to file did not store W");
  a_zero_wrap: assert property (zero_we && file_data == '1 && op == frx_pkg::increment_file_op
    |=> zero_o) else $error("wrap did not set zero");
  // Done follows the taking edge by three edges
  a_seq_done: assert property (state == st_idle && start_i |=> ##1 busy_o ##1 done_o)
    else $error("done not three cycles after start");
  // Completion pulse lasts one cycle
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  // Start while busy is ignored
  a_busy_ignore: assert property (state == st_read && start_i |=> state == st_exec && $stable(addr))
    else $error("start taken while busy");
  // Idle code writes neither W nor zero
  a_none_quiet: assert property (state == st_exec && op == frx_pkg::op_none |=> $stable(work_o) && $stable(zero_o))
    else $error("idle operation changed W or zero");

  // Main scenarios reached
  c_inc: cover property (done_o && $past(op) == frx_pkg::increment_file_op);
  c_or: cover property (done_o && $past(op) == frx_pkg::or_work_with_file_op);
  c_move: cover property (done_o && $past(op) == frx_pkg::move_file_op);
  c_move_work_to_file_op: cover property (done_o && $past(op) == frx_pkg::move_work_to_file_op);
  c_zero: cover property (zero_we && next_result == '0);
endmodule : frx_exec

// *** test/frx_exec_tb_top.sv ***
// Self-checking testbench for the file register execution datapath
`timescale 1ns/1ns
module frx_exec_tb_top;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic start_i = 1'b0;
  frx_pkg::frx_op_type op_i = frx_pkg::op_none;
  logic [6:0] file_addr_i = 7'h00;
  logic dest_i = 1'b0;
  logic busy_o;
  logic done_o;
  logic [7:0] work_o;
  logic zero_o;
  logic [7:0] result_o;
  int n_errors = 0;
  int n_checks = 0;

  // Device under test with the full 128 entry file
  frx_exec dut_u (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .start_i(start_i),
    .op_i(op_i),
    .file_addr_i(file_addr_i),
    .dest_i(dest_i),
    .busy_o(busy_o),
    .done_o(done_o),
    .work_o(work_o),
    .zero_o(zero_o),
    .result_o(result_o)
  );

  // 10 MHz clock
  initial begin
    forever #50 clock_i = ~clock_i;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Compare one value against its expectation
  task automatic check(input logic [7:0] seen, input logic [7:0] expected, input string what);
    n_checks++;
    if (seen !== expected) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, expected);
    end
  endtask : check

  // One operation, judged at the cycle its done pulse stands
  task automatic run_op(input frx_pkg::frx_op_type op, input logic [6:0] addr, input logic dest,
                        input logic [7:0] exp_res, input logic [7:0] exp_w, input logic exp_z);
    int k;
    k = 0;
    @(posedge clock_i);
    start_i <= 1'b1;
    op_i <= op;
    file_addr_i <= addr;
    dest_i <= dest;
    @(posedge clock_i);
    start_i <= 1'b0;
    do begin
      @(negedge clock_i);
      k++;
    end while (done_o !== 1'b1 && k < 10);
    if (k >= 10) begin
      check(8'h00, 8'h01, "done timeout");
      tally_and_finish();
    end else begin
      // Done stands at the third falling edge after the taking edge
      check(8'(k), 8'h03, "latency");
      check({7'h00, busy_o}, 8'h00, "busy at done");
      check(result_o, exp_res, "result");
      check(work_o, exp_w, "work");
      check({7'h00, zero_o}, {7'h00, exp_z}, "zero");
    end
  endtask : run_op

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    run_op(frx_pkg::increment_file_op, 7'h05, 1'b1, 8'h01, 8'h00, 1'b0);
    run_op(frx_pkg::increment_file_op, 7'h05, 1'b0, 8'h02, 8'h02, 1'b0);
    run_op(frx_pkg::move_file_op, 7'h05, 1'b0, 8'h01, 8'h01, 1'b0);
    run_op(frx_pkg::move_file_op, 7'h00, 1'b1, 8'h00, 8'h01, 1'b1);
    run_op(frx_pkg::move_work_to_file_op, 7'h09, 1'b0, 8'h01, 8'h01, 1'b1);
    run_op(frx_pkg::increment_file_op, 7'h09, 1'b1, 8'h02, 8'h01, 1'b0);
    run_op(frx_pkg::or_work_with_file_op, 7'h09, 1'b0, 8'h03, 8'h03, 1'b0);
    run_op(frx_pkg::or_work_with_file_op, 7'h05, 1'b1, 8'h03, 8'h03, 1'b0);
    run_op(frx_pkg::move_file_op, 7'h05, 1'b0, 8'h03, 8'h03, 1'b0);
    // Count one register up to all ones, then wrap it
    for (int i = 1; i < 256; i++) begin
      run_op(frx_pkg::increment_file_op, 7'h07, 1'b1, 8'(i), 8'h03, 1'b0);
    end
    run_op(frx_pkg::increment_file_op, 7'h07, 1'b1, 8'h00, 8'h03, 1'b1);
    // Idle code must leave W and the set zero flag alone
    run_op(frx_pkg::op_none, 7'h09, 1'b0, 8'h02, 8'h03, 1'b1);
    run_op(frx_pkg::move_file_op, 7'h00, 1'b0, 8'h00, 8'h00, 1'b1);
    run_op(frx_pkg::or_work_with_file_op, 7'h00, 1'b0, 8'h00, 8'h00, 1'b1);
    run_op(frx_pkg::or_work_with_file_op, 7'h09, 1'b0, 8'h02, 8'h02, 1'b0);
    run_op(frx_pkg::move_work_to_file_op, 7'h00, 1'b1, 8'h02, 8'h02, 1'b0);
    run_op(frx_pkg::move_file_op, 7'h00, 1'b0, 8'h02, 8'h02, 1'b0);
    tally_and_finish();
  end
endmodule : frx_exec_tb_top
